/* include/pirq_pkg.sv */
package pirq_pkg;

	// ****************************************
	// Register map (byte addresses, APB word aligned)
	// ****************************************
	localparam logic [11:0] REQ_FLAGS_1_OFS  = 12'h000;
	localparam logic [11:0] REQ_FLAGS_2_OFS  = 12'h004;
	localparam logic [11:0] PERIPH_EN_1_OFS  = 12'h008;
	localparam logic [11:0] PERIPH_EN_2_OFS  = 12'h00C;
	localparam logic [11:0] IRQ_CTRL_OFS     = 12'h010;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] REQ_FLAGS_RST  = 8'h00;
	localparam logic [7:0] PERIPH_EN_RST  = 8'h00;
	localparam logic [1:0] IRQ_CTRL_RST   = 2'b00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int TIMER_ONE_GATE_BIT     = 7;
	localparam int CONVERSION_DONE_BIT    = 6;
	localparam int SERIAL_RX_BIT          = 5;
	localparam int SERIAL_TX_BIT          = 4;
	localparam int SYNC_SERIAL_BIT        = 3;
	localparam int CAPCMP_ONE_BIT         = 2;
	localparam int TIMER_TWO_MATCH_BIT    = 1;
	localparam int TIMER_ONE_OVERFLOW_BIT = 0;
	localparam int OSC_FAIL_BIT           = 7;
	localparam int COMPARATOR_B_BIT       = 6;
	localparam int COMPARATOR_A_BIT       = 5;
	localparam int NV_WRITE_DONE_BIT      = 4;
	localparam int BUS_COLLISION_BIT      = 3;
	localparam int CAPCMP_TWO_BIT         = 0;
	localparam int GLOBAL_IRQ_EN_BIT      = 1;
	localparam int PERIPH_IRQ_EN_BIT      = 0;

	// Writable masks: serial flags are read-only, bits 2..1 of reg 2 unimplemented
	localparam logic [7:0] FLAGS_1_WMASK = 8'hCF;
	localparam logic [7:0] FLAGS_2_IMPL  = 8'hF9;

	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : pirq_pkg

/* verilog/pirq_flag_regs.sv */
// Function
// RULE_01: Flag sets on its event regardless of any enable bit.
// RULE_02: Software clears a flag before enabling its interrupt.
// RULE_03: One means pending, zero means not pending.
// RULE_04: All implemented flags reset to zero on every reset. Code: reg 1 serial bits 5..4 keep following their peripheral through reset.
// RULE_05: Serial receive/transmit flags read-only, follow their peripheral.
// RULE_06: Reg 1 bit 7 timer-one gate, bit 6 conversion done, read/write.
// RULE_07: Reg 1 bit 3 sync serial, bit 2 capture/compare one.
// RULE_08: Reg 1 bit 1 timer-two match, bit 0 timer-one overflow.
// RULE_09: Reg 2 bit 7 latches oscillator failure.
// RULE_10: Reg 2 bit 6 comparator B, bit 5 comparator A.
// RULE_11: Reg 2 bit 4 sets when nonvolatile write finishes.
// RULE_12: Reg 2 bit 3 sets on sync serial bus collision.
// RULE_13: Reg 2 bit 0 capture/compare two; bits 2..1 read zero.
// RULE_14: Interrupt only when flag, its enable, peripheral and global enables set.
// RULE_15: Writes store value; a simultaneous event beats a clear.
// RULE_16: Events are one-cycle pulses; flags hold until cleared or reset.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pirq_flag_regs
	import pirq_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [31:0] prdata,
	input  wire logic        timerOneGateEvent,
	input  wire logic        conversionDoneEvent,
	input  wire logic        serialRxPending,
	input  wire logic        serialTxPending,
	input  wire logic        syncSerialEvent,
	input  wire logic        capcmpOneEvent,
	input  wire logic        timerTwoMatchEvent,
	input  wire logic        timerOneOverflowEvent,
	input  wire logic        oscFailEvent,
	input  wire logic        comparatorBEvent,
	input  wire logic        comparatorAEvent,
	input  wire logic        nvWriteDoneEvent,
	input  wire logic        busCollisionEvent,
	input  wire logic        capcmpTwoEvent,
	output logic      [7:0]  periphRequestFlags1,
	output logic      [7:0]  periphRequestFlags2,
	output logic             cpuIrq
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]  flags1;
		logic [7:0]  flags2;
		logic [7:0]  enable1;
		logic [7:0]  enable2;
		logic [1:0]  irqCtrl;
		logic [31:0] rdata;
		logic        slvErr;
		logic        irq;
	} pirq_state_t;

	pirq_state_t state;
	pirq_state_t next_state;

	logic [7:0] events1;
	logic [7:0] events2;
	logic [7:0] flags1View;
	logic       wrAccess;
	logic       rdAccess;
	logic       knownAddr;

	// ****************************************
	// Event gathering
	// ****************************************
	always_comb
	begin
		events1 = 8'h00;
		events1[TIMER_ONE_GATE_BIT]     = timerOneGateEvent;     // RULE_06
		events1[CONVERSION_DONE_BIT]    = conversionDoneEvent;   // RULE_06
		events1[SYNC_SERIAL_BIT]        = syncSerialEvent;       // RULE_07
		events1[CAPCMP_ONE_BIT]         = capcmpOneEvent;        // RULE_07
		events1[TIMER_TWO_MATCH_BIT]    = timerTwoMatchEvent;    // RULE_08
		events1[TIMER_ONE_OVERFLOW_BIT] = timerOneOverflowEvent; // RULE_08
		events2 = 8'h00;
		events2[OSC_FAIL_BIT]      = oscFailEvent;      // RULE_09
		events2[COMPARATOR_B_BIT]  = comparatorBEvent;  // RULE_10
		events2[COMPARATOR_A_BIT]  = comparatorAEvent;  // RULE_10
		events2[NV_WRITE_DONE_BIT] = nvWriteDoneEvent;  // RULE_11
		events2[BUS_COLLISION_BIT] = busCollisionEvent; // RULE_12
		events2[CAPCMP_TWO_BIT]    = capcmpTwoEvent;    // RULE_13
	end

	// Serial flags mirror the peripheral level, so no storage for them
	always_comb
	begin
		flags1View = state.flags1 & FLAGS_1_WMASK;
		flags1View[SERIAL_RX_BIT] = serialRxPending; // RULE_05
		flags1View[SERIAL_TX_BIT] = serialTxPending; // RULE_05
	end

	// ****************************************
	// APB decode
	// ****************************************
	assign wrAccess  = psel && penable && pwrite;
	assign rdAccess  = psel && !penable && !pwrite;
	assign knownAddr = (paddr == REQ_FLAGS_1_OFS) || (paddr == REQ_FLAGS_2_OFS)
		|| (paddr == PERIPH_EN_1_OFS) || (paddr == PERIPH_EN_2_OFS)
		|| (paddr == IRQ_CTRL_OFS);

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		next_state = state;
		// Write first, then OR in events so a same-cycle event beats a clear
		if (wrAccess)
		begin
			unique case (paddr)
				REQ_FLAGS_1_OFS: next_state.flags1 = pwdata[7:0] & FLAGS_1_WMASK; // RULE_15 RULE_05
				REQ_FLAGS_2_OFS: next_state.flags2 = pwdata[7:0] & FLAGS_2_IMPL;  // RULE_15 RULE_13
				PERIPH_EN_1_OFS: next_state.enable1 = pwdata[7:0];
				PERIPH_EN_2_OFS: next_state.enable2 = pwdata[7:0] & FLAGS_2_IMPL;
				IRQ_CTRL_OFS:    next_state.irqCtrl = pwdata[1:0];
				default:         next_state.irqCtrl = state.irqCtrl;
			endcase
		end
		// Set regardless of enables; held until software or reset clears
		next_state.flags1 = next_state.flags1 | events1; // RULE_01 RULE_16 RULE_03
		next_state.flags2 = next_state.flags2 | events2; // RULE_01 RULE_16 RULE_03
		// Read data captured in setup, stands during the access phase
		if (rdAccess)
		begin
			unique case (paddr)
				REQ_FLAGS_1_OFS: next_state.rdata = {24'h00_0000, flags1View};
				REQ_FLAGS_2_OFS: next_state.rdata = {24'h00_0000, state.flags2 & FLAGS_2_IMPL}; // RULE_13
				PERIPH_EN_1_OFS: next_state.rdata = {24'h00_0000, state.enable1};
				PERIPH_EN_2_OFS: next_state.rdata = {24'h00_0000, state.enable2};
				IRQ_CTRL_OFS:    next_state.rdata = {30'h0000_0000, state.irqCtrl};
				default:         next_state.rdata = RDATA_ZERO;
			endcase
		end
		next_state.slvErr = psel && !penable && !knownAddr;
		// Requires flag, its enable, peripheral enable and global enable
		next_state.irq = state.irqCtrl[GLOBAL_IRQ_EN_BIT] && state.irqCtrl[PERIPH_IRQ_EN_BIT]
			&& (|(flags1View & state.enable1) || |(state.flags2 & state.enable2)); // RULE_14
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			state         <= '0;
			state.flags1  <= REQ_FLAGS_RST; // RULE_04
			state.flags2  <= REQ_FLAGS_RST; // RULE_04
			state.enable1 <= PERIPH_EN_RST;
			state.enable2 <= PERIPH_EN_RST;
			state.irqCtrl <= IRQ_CTRL_RST;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign pready              = 1'b1;
	assign pslverr             = psel && penable && state.slvErr;
	assign prdata              = state.rdata;
	assign periphRequestFlags1 = flags1View;
	assign periphRequestFlags2 = state.flags2 & FLAGS_2_IMPL;
	assign cpuIrq              = state.irq;

endmodule : pirq_flag_regs

`default_nettype wire

/* test/pirq_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pirq_properties(
	input wire logic       clk, rst_b, psel, penable, pwrite, pslverr, serialRxPending,
	input wire logic       timerOneGateEvent, timerOneOverflowEvent, oscFailEvent,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [7:0]  periphRequestFlags1, periphRequestFlags2
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ****
	// Write then compare: an event at the write edge must beat the data
	// ****
	sequence s_wr1;
		psel && penable && pwrite && paddr == 12'h000;
	endsequence
	sequence s_set7;
		periphRequestFlags1[7] == ($past(pwdata[7]) || $past(timerOneGateEvent));
	endsequence
	a_flag_reset: assert property (disable iff (1'b0) !rst_b |=>
		(periphRequestFlags1 & 8'hCF) == 8'h00 && periphRequestFlags2 == 8'h00)
		else $error("flags not cleared by reset");
	a_write_store: assert property (s_wr1 |=> s_set7)
		else $error("reg 1 bit 7 wrong after write");
	a_osc_latch: assert property (oscFailEvent |=> periphRequestFlags2[7])
		else $error("oscillator fail not latched");
	a_ovf_latch: assert property (timerOneOverflowEvent |=> periphRequestFlags1[0])
		else $error("overflow not latched");
	a_unimpl_zero: assert property (periphRequestFlags2[2:1] == 2'b00)
		else $error("unimplemented bits set");
	a_serial_live: assert property (periphRequestFlags1[5] == serialRxPending)
		else $error("receive flag not following peripheral");
	a_osc_hold: assert property (periphRequestFlags2[7] &&
		!(psel && penable && pwrite && paddr == 12'h004) |=> periphRequestFlags2[7])
		else $error("flag lost without a clear");
	a_unmapped_err: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
		else $error("no error on unmapped address");
endmodule : pirq_properties
`default_nettype wire

/* test/pirq_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Peripherals: each request comes out as an event pulse one clock later
module pirq_periph_model(
	input wire logic [11:0] trig,
	input wire logic        clk,
	output var logic [11:0] ev
);
	always_ff @(posedge clk)
	begin
		ev <= trig;
	end
endmodule : pirq_periph_model
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import pirq_pkg::*;;
	logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, rx = 0, tx = 0;
	logic [11:0] paddr = 0, trig = 0, ev;
	logic [31:0] pwdata = 0, prdata, rdat;
	logic rerr, rdy, pready, pslverr, cpuIrq;
	logic [7:0] f1, f2, x1 = 0, x2 = 0;
	int miscompares = 0, n_compared = 0, seed = 32'h8d1a, n;
	always #2 clk = ~clk;
	pirq_periph_model per_u(.clk, .trig, .ev);
	pirq_flag_regs dut_u(.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.pslverr, .prdata, .timerOneGateEvent(ev[11]), .conversionDoneEvent(ev[10]),
		.serialRxPending(rx), .serialTxPending(tx), .syncSerialEvent(ev[9]),
		.capcmpOneEvent(ev[8]), .timerTwoMatchEvent(ev[7]), .timerOneOverflowEvent(ev[6]),
		.oscFailEvent(ev[5]), .comparatorBEvent(ev[4]), .comparatorAEvent(ev[3]),
		.nvWriteDoneEvent(ev[2]), .busCollisionEvent(ev[1]), .capcmpTwoEvent(ev[0]),
		.periphRequestFlags1(f1), .periphRequestFlags2(f2), .cpuIrq);
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s exp %h seen %h", s, exp, seen);
		end
	endtask : chk
	// Events are launched in setup so they land on the write edge
	task automatic apb(logic w, logic [11:0] a, logic [7:0] d, logic [11:0] e = 0);
		@(posedge clk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d}; trig <= e;
		@(posedge clk);
		trig <= 0;
		penable <= 1;
		n = 0;
		do
		begin
			// Answer taken at the rising edge that ends the access phase
			@(posedge clk);
			n++;
			rdat = prdata;
			rerr = pslverr;
			rdy = pready;
		end
		while (!rdy && n < 9);
		psel <= 0;
		penable <= 0;
		if (!rdy)
		begin
			miscompares++;
			end_sim();
		end
		if (w && a == 0) x1 = d & 8'hCF;
		if (w && a == 4) x2 = d & 8'hF9;
		x1 |= {e[11:10], 2'b00, e[9:6]};
		x2 |= {e[5:1], 2'b00, e[0]};
	endtask : apb
	task automatic rd(logic [11:0] a);
		apb(0, a, 0);
		chk("flags", rdat, {24'h0, a == 0 ? x1 | {2'b00, rx, tx, 4'h0} : x2});
		chk("flags1 pins", f1, x1 | {2'b00, rx, tx, 4'h0});
		chk("flags2 pins", f2, x2);
	endtask : rd
	initial
	begin
		repeat (8) @(posedge clk);
		rst_b <= 1;
		rd(0);
		rd(4);
		for (int i = 0; i < 12; i++)
		begin
			apb(0, 12'h010, 0, 12'h001 << i);
			rd(0);
			rd(4);
			chk("irq", cpuIrq, 0);
		end
		for (int i = 0; i < 40; i++)
		begin
			rx <= 1'($random(seed));
			tx <= 1'($random(seed));
			apb(1, {9'h0, 1'($random(seed)), 2'b0}, 8'($random(seed)), 12'($random(seed)));
			rd(0);
			rd(4);
		end
		apb(1, 0, 0);
		apb(1, 12'h008, 8'h01);
		apb(1, 12'h010, 8'h03);
		chk("irq", cpuIrq, 0);
		apb(1, 12'h010, 8'h03, 12'h040);
		apb(0, 12'h010, 0);
		chk("irq", cpuIrq, 1);
		apb(1, 12'h010, 8'h01);
		apb(0, 12'h010, 0);
		chk("irq", cpuIrq, 0);
		apb(0, 12'h020, 0);
		chk("err", rerr, 1);
		chk("rdat", rdat, 0);
		rst_b <= 0;
		repeat (2) @(posedge clk);
		rst_b <= 1;
		x1 = 0;
		x2 = 0;
		rd(0);
		rd(4);
		end_sim();
	end
endmodule : testbench
bind pirq_flag_regs pirq_properties chk_u(.clk, .rst_b, .psel, .penable, .pwrite, .pslverr,
	.serialRxPending, .timerOneGateEvent, .timerOneOverflowEvent, .oscFailEvent, .paddr,
	.pwdata, .periphRequestFlags1, .periphRequestFlags2);
`default_nettype wire
